// File: test/ref_pulse_model.sv
`timescale 1ns/1ps
`default_nettype none
module ref_pulse_model (
   input wire logic win_req_i,
   output logic low_freq_clk_o,
   output logic high_freq_clk_o,
   output logic reference_pulse_o
);
   // the low oscillator runs free, unrelated in phase to the system clock; the high one is phase-locked at eight system cycles
   initial begin
      low_freq_clk_o = 1'b0;
      high_freq_clk_o = 1'b0;
      reference_pulse_o = 1'b0;
   end
   always #15259 low_freq_clk_o = ~low_freq_clk_o;
   always #200 high_freq_clk_o = ~high_freq_clk_o;
   // one precise window of ten high source periods per request
   always @(posedge win_req_i) begin
      reference_pulse_o = 1'b1;
      #4000;
      reference_pulse_o = 1'b0;
   end
endmodule
`default_nettype wire

// File: test/test_calendar_clock_with_trim.sv
`timescale 1ns/1ps
`default_nettype none
module test_calendar_clock_with_trim;
   localparam logic [11:0] A_CTRL = rtc_pkg::ADDR_CTRL_FIRST;
   localparam logic [11:0] A_STAT = rtc_pkg::ADDR_STATUS;
   localparam logic [11:0] A_TIME = rtc_pkg::ADDR_TIME;
   localparam logic [11:0] A_AUX = rtc_pkg::ADDR_AUX;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic lo_clk;
   logic hi_clk;
   logic ref_pin;
   logic pulse;
   logic win_req = 1'b0;
   logic [31:0] rd;
   logic [31:0] t0;
   int num_errors = 0;
   int samples_checked = 0;
   int rises = 0;
   always #25 clk_i = ~clk_i;
   always @(posedge pulse) rises++;
   calendar_clock_with_trim u_calendar_clock_with_trim (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .low_freq_clk_i(lo_clk),
      .high_freq_clk_i(hi_clk), .reference_pulse_in_i(ref_pin),
      .seconds_pulse_out_o(pulse));
   ref_pulse_model u_ref_pulse_model (
      .win_req_i(win_req), .low_freq_clk_o(lo_clk),
      .high_freq_clk_o(hi_clk), .reference_pulse_o(ref_pin));
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // looks just after each edge, so ack is known before the edge samples it
   task automatic xfer(input logic [11:0] a, input logic we,
                       input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         close_out();
      end
      @(posedge clk_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic wait_reg(input logic [11:0] a, input logic [31:0] mask,
                           input logic [31:0] val);
      int n;
      n = 0;
      do begin
         xfer(a, 1'b0, 32'h0);
         n++;
      end while ((rd & mask) !== val && n < 400);
      if (n >= 400) begin
         $display("CHECK FAILED poll %h expected %h seen %h", a, val, rd);
         num_errors++;
         close_out();
      end
   endtask
   task automatic t_reset_values;
      xfer(A_CTRL, 1'b0, 32'h0);
      check("ctrl reset", rd, {24'h0, rtc_pkg::CTRL_RESET});
      xfer(rtc_pkg::ADDR_CORR, 1'b0, 32'h0);
      check("corr reset", rd, {12'h0, rtc_pkg::CORR_RESET});
      xfer(12'hFFC, 1'b1, 32'hFFFFFFFF);
      xfer(12'hFFC, 1'b0, 32'h0);
      check("unmapped read", rd, 32'h0);
      $display("test reset_values done");
   endtask
   task automatic t_source;
      xfer(A_CTRL, 1'b1, 32'h8E);
      xfer(A_CTRL, 1'b0, 32'h0);
      check("ctrl readback", rd, 32'h8E);
      repeat (40) @(posedge clk_i);
      wait_reg(A_STAT, 32'h6, 32'h0);
      xfer(A_CTRL, 1'b1, 32'h80);
      repeat (40) @(posedge clk_i);
      wait_reg(A_STAT, 32'h6, 32'h0);
      xfer(A_CTRL, 1'b1, 32'h04);
      xfer(A_CTRL, 1'b1, 32'h84);
      wait_reg(A_STAT, 32'h2, 32'h2);
      xfer(A_CTRL, 1'b1, 32'h00);
      wait_reg(A_STAT, 32'h6, 32'h0);
      $display("test source done");
   endtask
   task automatic t_second;
      xfer(A_AUX, 1'b1, 32'h40);
      xfer(A_CTRL, 1'b1, 32'h02);
      xfer(A_AUX, 1'b1, 32'h01);
      wait_reg(A_STAT, 32'hC, 32'h4);
      repeat (1600) @(posedge clk_i);
      xfer(A_AUX, 1'b1, 32'h21);
      xfer(rtc_pkg::ADDR_CAP_B, 1'b0, 32'h0);
      // one low source edge per 610 system cycles
      check("second count", {31'h0, rd >= 2 && rd <= 4}, 32'h1);
      xfer(A_AUX, 1'b1, 32'h00);
      wait_reg(A_STAT, 32'h6, 32'h0);
      $display("test second done");
   endtask
   task automatic t_tick;
      longint ts;
      int cyc;
      xfer(rtc_pkg::ADDR_CORR, 1'b1, 32'h00009);
      xfer(A_CTRL, 1'b1, 32'h05);
      wait_reg(A_STAT, 32'h1, 32'h1);
      xfer(A_TIME, 1'b1, 32'h00000059);
      xfer(A_AUX, 1'b1, 32'h44);
      rises = 0;
      xfer(A_CTRL, 1'b1, 32'h84);
      wait_reg(A_TIME, 32'hFFFFFF, 32'h000100);
      ts = $time;
      wait_reg(A_TIME, 32'hFFFFFF, 32'h000101);
      cyc = int'(($time - ts) / 50);
      // ten high source periods of eight system cycles, less poll jitter
      check("second period", {31'h0, cyc >= 74 && cyc <= 86}, 32'h1);
      check("pulse seen", {31'h0, rises > 0}, 32'h1);
      $display("test tick done");
   endtask
   task automatic t_hold;
      xfer(A_CTRL, 1'b1, 32'h85);
      wait_reg(A_STAT, 32'h1, 32'h1);
      xfer(A_TIME, 1'b0, 32'h0);
      t0 = rd;
      repeat (200) @(posedge clk_i);
      xfer(A_TIME, 1'b0, 32'h0);
      check("held time", rd, t0);
      $display("test hold done");
   endtask
   task automatic t_reset_keep;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      xfer(A_CTRL, 1'b0, 32'h0);
      check("ctrl after reset", rd, 32'h0);
      xfer(A_TIME, 1'b0, 32'h0);
      check("time kept", rd, t0);
      repeat (200) @(posedge clk_i);
      xfer(A_TIME, 1'b0, 32'h0);
      check("stopped by reset", rd, t0);
      $display("test reset_keep done");
   endtask
   task automatic t_measure;
      xfer(A_CTRL, 1'b1, 32'h04);
      xfer(A_AUX, 1'b1, 32'h40);
      xfer(A_CTRL, 1'b1, 32'hC4);
      win_req <= 1'b1;
      repeat (200) @(posedge clk_i);
      xfer(A_AUX, 1'b1, 32'h10);
      xfer(rtc_pkg::ADDR_CAP_A, 1'b0, 32'h0);
      check("window count", {31'h0, rd >= 9 && rd <= 11}, 32'h1);
      xfer(A_CTRL, 1'b1, 32'h00);
      win_req <= 1'b0;
      $display("test measure done");
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset_values();
      t_source();
      t_second();
      t_tick();
      t_hold();
      t_reset_keep();
      t_measure();
      close_out();
   end
endmodule
`default_nettype wire

// File: verilog/calendar_clock_with_trim.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module calendar_clock_with_trim (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic low_freq_clk_i,
   input wire logic high_freq_clk_i,
   input wire logic reference_pulse_in_i,
   output logic seconds_pulse_out_o
);
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   rtc_pkg::aux_ctrl_t aux;
   rtc_pkg::aux_ctrl_t next_aux;
   logic [19:0] corr;
   logic [19:0] next_corr;
   logic [31:0] corr_word;
   logic hold_ack;
   logic [31:0] next_dat;
   logic next_ack;
   logic req;
   logic wr;
   logic [2:0] sync_level;
   logic [2:0] sync_rise;
   logic low_rise;
   logic high_rise;
   logic ref_level;
   logic [3:0] div;
   logic [3:0] next_div;
   logic tick_a;
   logic src_valid;
   logic active_a;
   logic active_b;
   logic measure_a;
   logic window_a;
   logic window_b;
   logic clear_pre;
   logic sec_tick;
   logic cal_step;
   // prescalers keep their counts across reset; power-up value only
   logic [19:0] cnt_a = rtc_pkg::PRESCALE_INIT;
   logic [19:0] cnt_b = rtc_pkg::PRESCALE_INIT;
   logic [19:0] next_cnt_a;
   logic [19:0] next_cnt_b;
   logic [19:0] cap_a;
   logic [19:0] cap_b;
   logic [19:0] next_cap_a;
   logic [19:0] next_cap_b;
   logic pulse;
   logic next_pulse;
   logic [11:0] stall_cnt;
   logic [11:0] next_stall_cnt;
   logic low_stalled;
   rtc_pkg::cal_t cal;
   rtc_pkg::cal_t load_val;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         old[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
      end
      merge = old;
   endfunction

   pin_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i({reference_pulse_in_i, high_freq_clk_i, low_freq_clk_i}),
      .level_o(sync_level),
      .rise_o(sync_rise)
   );

   assign low_rise = sync_rise[0];
   assign high_rise = sync_rise[1];
   assign ref_level = sync_level[2];

   // ---- bus slave: ack one cycle after the request, write at ack edge
   assign req = wb_cyc_i & wb_stb_i;
   assign next_ack = req & ~wb_ack_o;
   assign wr = req & wb_we_i & wb_ack_o;

   always_comb begin
      next_dat = 32'h0000_0000;
      if (wb_adr_i == rtc_pkg::ADDR_CTRL_FIRST) begin
         next_dat = {24'h00_0000, ctrl};
      end else if (wb_adr_i == rtc_pkg::ADDR_STATUS) begin
         next_dat = {26'h000_0000, aux.measure_b, measure_a, low_stalled,
                     active_b, active_a, hold_ack};
      end else if (wb_adr_i == rtc_pkg::ADDR_CORR) begin
         next_dat = {12'h000, corr};
      end else if (wb_adr_i == rtc_pkg::ADDR_AUX) begin
         next_dat = {28'h000_0000, aux.ref_internal, aux.pulse_en,
                     aux.measure_b, aux.run_b};
      end else if (wb_adr_i == rtc_pkg::ADDR_CAP_A) begin
         next_dat = {12'h000, cap_a};
      end else if (wb_adr_i == rtc_pkg::ADDR_CAP_B) begin
         next_dat = {12'h000, cap_b};
      end else if (wb_adr_i == rtc_pkg::ADDR_TIME) begin
         next_dat = {8'h00, cal.hour, cal.minute, cal.second};
      end else if (wb_adr_i == rtc_pkg::ADDR_DATE) begin
         next_dat = {8'h00, cal.year, cal.month, cal.day};
      end else if (wb_adr_i == rtc_pkg::ADDR_WEEK) begin
         next_dat = {26'h000_0000, cal.leap, 1'b0, cal.weekday};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= next_ack;
         if (next_ack) begin
            wb_dat_o <= next_dat;
         end
      end
   end

   // ---- control registers
   always_comb begin
      next_ctrl = ctrl;
      next_aux = aux;
      next_corr = corr;
      corr_word = merge({12'h000, corr}, wb_dat_i, wb_sel_i);
      if (wr && wb_sel_i[0] && wb_adr_i == rtc_pkg::ADDR_CTRL_FIRST) begin
         next_ctrl = wb_dat_i[7:0];
      end
      if (wr && wb_sel_i[0] && wb_adr_i == rtc_pkg::ADDR_AUX) begin
         next_aux.run_b = wb_dat_i[rtc_pkg::AUX_RUN_B_BIT];
         next_aux.measure_b = wb_dat_i[rtc_pkg::AUX_MEASURE_B_BIT];
         next_aux.pulse_en = wb_dat_i[rtc_pkg::AUX_PULSE_EN_BIT];
         next_aux.ref_internal = wb_dat_i[rtc_pkg::AUX_REF_INT_BIT];
      end
      if (wr && wb_adr_i == rtc_pkg::ADDR_CORR) begin
         next_corr = corr_word[19:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= rtc_pkg::CTRL_RESET;
         aux <= rtc_pkg::AUX_RESET;
         corr <= rtc_pkg::CORR_RESET;
         hold_ack <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         aux <= next_aux;
         corr <= next_corr;
         hold_ack <= ctrl[rtc_pkg::CTRL_HOLD_BIT];
      end
   end

   // ---- source selection and high clock divider
   assign measure_a = ctrl[rtc_pkg::CTRL_MEASURE_BIT];
   assign next_div = high_rise ? div + 4'h1 : div;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div <= 4'h0;
      end else begin
         div <= next_div;
      end
   end

   always_comb begin
      tick_a = 1'b0;
      src_valid = 1'b1;
      case (rtc_pkg::src_sel_t'(ctrl[rtc_pkg::CTRL_SRC_LSB +: 3]))
         rtc_pkg::SRC_LOW: tick_a = low_rise;
         rtc_pkg::SRC_HIGH: tick_a = high_rise;
         rtc_pkg::SRC_HIGH_DIV2: tick_a = high_rise & div[0];
         rtc_pkg::SRC_HIGH_DIV4: tick_a = high_rise & (&div[1:0]);
         rtc_pkg::SRC_HIGH_DIV8: tick_a = high_rise & (&div[2:0]);
         rtc_pkg::SRC_HIGH_DIV16: tick_a = high_rise & (&div);
         default: src_valid = 1'b0;
      endcase
   end

   // reset freezes counts at once, before ctrl has cleared
   assign active_a = ctrl[rtc_pkg::CTRL_RUN_BIT] & src_valid & ~rst_i;
   assign active_b = aux.run_b & src_valid & ~rst_i;
   assign window_a = ref_level;
   // internal seconds pulse replaces the pin for the low clock trim
   assign window_b = aux.ref_internal ? pulse : ref_level;
   assign clear_pre = wr && wb_sel_i[0] && wb_adr_i == rtc_pkg::ADDR_AUX
                      && wb_dat_i[rtc_pkg::AUX_CLEAR_BIT];

   // ---- prescale counters
   always_comb begin
      next_cnt_a = cnt_a;
      next_cnt_b = cnt_b;
      sec_tick = 1'b0;
      if (clear_pre) begin
         next_cnt_a = rtc_pkg::PRESCALE_INIT;
         next_cnt_b = rtc_pkg::PRESCALE_INIT;
      end else begin
         if (active_a && tick_a) begin
            if (measure_a) begin
               if (window_a) begin
                  next_cnt_a = cnt_a + 20'h00001;
               end
            end else if (cnt_a == corr) begin
               next_cnt_a = rtc_pkg::PRESCALE_INIT;
               sec_tick = 1'b1;
            end else begin
               next_cnt_a = cnt_a + 20'h00001;
            end
         end
         if (active_b && low_rise && (!aux.measure_b || window_b)) begin
            next_cnt_b = cnt_b + 20'h00001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      cnt_a <= next_cnt_a;
      cnt_b <= next_cnt_b;
   end

   // ---- capture, seconds pulse, low clock watchdog
   assign cal_step = sec_tick & ~ctrl[rtc_pkg::CTRL_HOLD_BIT];

   always_comb begin
      next_cap_a = cap_a;
      next_cap_b = cap_b;
      if (wr && wb_sel_i[0] && wb_adr_i == rtc_pkg::ADDR_AUX) begin
         if (wb_dat_i[rtc_pkg::AUX_CAP_A_BIT]) begin
            next_cap_a = cnt_a;
         end
         if (wb_dat_i[rtc_pkg::AUX_CAP_B_BIT]) begin
            next_cap_b = cnt_b;
         end
      end
      // high for the first half of each second
      next_pulse = pulse;
      if (!aux.pulse_en) begin
         next_pulse = 1'b0;
      end else if (sec_tick) begin
         next_pulse = 1'b1;
      end else if (active_a && tick_a && cnt_a == {1'b0, corr[19:1]}) begin
         next_pulse = 1'b0;
      end
      // counts clk cycles since the last low clock edge
      if (low_rise) begin
         next_stall_cnt = 12'h000;
      end else if (low_stalled) begin
         next_stall_cnt = stall_cnt;
      end else begin
         next_stall_cnt = stall_cnt + 12'h001;
      end
   end

   assign low_stalled = (stall_cnt == 12'(rtc_pkg::STALL_CYCLES));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_a <= rtc_pkg::PRESCALE_INIT;
         cap_b <= rtc_pkg::PRESCALE_INIT;
         pulse <= 1'b0;
         stall_cnt <= 12'h000;
      end else begin
         cap_a <= next_cap_a;
         cap_b <= next_cap_b;
         pulse <= next_pulse;
         stall_cnt <= next_stall_cnt;
      end
   end

   assign seconds_pulse_out_o = pulse;

   // ---- calendar
   always_comb begin
      load_val = rtc_pkg::CAL_INIT;
      load_val.hour = wb_dat_i[23:16];
      load_val.minute = wb_dat_i[15:8];
      load_val.second = wb_dat_i[7:0];
      if (wb_adr_i == rtc_pkg::ADDR_DATE) begin
         load_val.year = wb_dat_i[23:16];
         load_val.month = wb_dat_i[15:8];
         load_val.day = wb_dat_i[7:0];
      end
      load_val.leap = wb_dat_i[5:4];
      load_val.weekday = wb_dat_i[2:0];
   end

   calendar_counter u_cal (
      .clk_i(clk_i),
      .sec_tick_i(cal_step),
      .load_time_i(wr && hold_ack && wb_adr_i == rtc_pkg::ADDR_TIME),
      .load_date_i(wr && hold_ack && wb_adr_i == rtc_pkg::ADDR_DATE),
      .load_week_i(wr && hold_ack && wb_adr_i == rtc_pkg::ADDR_WEEK),
      .load_val_i(load_val),
      .cal_o(cal)
   );

   // ---- assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_reset_stops;
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> (ctrl == 8'h00) && !active_a && !pulse;
   endproperty
   a_reset_stops: assert property (p_reset_stops)
      else $error("reset did not stop the clock");

   property p_wrap;
      active_a && tick_a && !measure_a && !clear_pre && cnt_a == corr
      |=> cnt_a == 20'h00000;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("prescaler did not restart on match");

   property p_step;
      active_a && tick_a && !measure_a && !clear_pre && cnt_a != corr
      |=> cnt_a == $past(cnt_a) + 20'h00001;
   endproperty
   a_step: assert property (p_step)
      else $error("prescaler did not step");

   property p_stopped_codes;
      (ctrl[3:1] == 3'b000 || ctrl[3:1] == 3'b111) |-> !active_a && !active_b;
   endproperty
   a_stopped_codes: assert property (p_stopped_codes)
      else $error("prescaler active on stop code");

   property p_hold;
      sec_tick && ctrl[0] && !wr |=> $stable(cal.second);
   endproperty
   a_hold: assert property (p_hold)
      else $error("calendar advanced while held");

   property p_gate;
      measure_a && !window_a && !clear_pre |=> $stable(cnt_a);
   endproperty
   a_gate: assert property (p_gate)
      else $error("measurement counted outside window");

   property p_capture;
      wr && wb_sel_i[0] && wb_adr_i == 12'hFAC && wb_dat_i[4]
      |=> cap_a == $past(cnt_a);
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture value wrong");

   property p_locked_write;
      wr && !hold_ack && wb_adr_i == 12'hFB8 && !cal_step
      |=> $stable(cal.minute) && $stable(cal.hour);
   endproperty
   a_locked_write: assert property (p_locked_write)
      else $error("time written without hold acknowledge");

   property p_pulse;
      sec_tick && aux.pulse_en |=> seconds_pulse_out_o;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("seconds pulse missing");

   property p_ack_drop;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_drop: assert property (p_ack_drop)
      else $error("ack held two cycles");
endmodule
`default_nettype wire

// File: verilog/calendar_counter.sv
`timescale 1ns/1ps
`default_nettype none
module calendar_counter (
   input wire logic clk_i,
   input wire logic sec_tick_i,
   input wire logic load_time_i,
   input wire logic load_date_i,
   input wire logic load_week_i,
   input wire rtc_pkg::cal_t load_val_i,
   output rtc_pkg::cal_t cal_o
);
   // power-up value only; no reset so the calendar survives every reset
   rtc_pkg::cal_t cal = rtc_pkg::CAL_INIT;
   rtc_pkg::cal_t next_cal;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   function automatic logic [7:0] month_days(input logic [7:0] m,
                                             input logic [1:0] lp);
      if (m == 8'h02) begin
         month_days = (lp == 2'h0) ? 8'h29 : 8'h28;
      end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
         month_days = 8'h30;
      end else begin
         month_days = 8'h31;
      end
   endfunction

   always_comb begin
      next_cal = cal;
      if (sec_tick_i) begin
         next_cal.second = bcd_inc(cal.second);
         if (cal.second == 8'h59) begin
            next_cal.second = 8'h00;
            next_cal.minute = bcd_inc(cal.minute);
            if (cal.minute == 8'h59) begin
               next_cal.minute = 8'h00;
               next_cal.hour = bcd_inc(cal.hour);
               if (cal.hour == 8'h23) begin
                  next_cal.hour = 8'h00;
                  next_cal.weekday = (cal.weekday == 3'h6) ? 3'h0
                                     : cal.weekday + 3'h1;
                  next_cal.day = bcd_inc(cal.day);
                  if (cal.day == month_days(cal.month, cal.leap)) begin
                     next_cal.day = 8'h01;
                     next_cal.month = bcd_inc(cal.month);
                     if (cal.month == 8'h12) begin
                        next_cal.month = 8'h01;
                        next_cal.year = (cal.year == 8'h99) ? 8'h00
                                        : bcd_inc(cal.year);
                        next_cal.leap = cal.leap + 2'h1;
                     end
                  end
               end
            end
         end
      end
      // software load wins over a tick in the same cycle
      if (load_time_i) begin
         next_cal.hour = load_val_i.hour;
         next_cal.minute = load_val_i.minute;
         next_cal.second = load_val_i.second;
      end
      if (load_date_i) begin
         next_cal.year = load_val_i.year;
         next_cal.month = load_val_i.month;
         next_cal.day = load_val_i.day;
      end
      if (load_week_i) begin
         next_cal.weekday = load_val_i.weekday;
         next_cal.leap = load_val_i.leap;
      end
   end

   always_ff @(posedge clk_i) begin
      cal <= next_cal;
   end

   assign cal_o = cal;
endmodule
`default_nettype wire

// File: verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   logic [WIDTH-1:0] next_level;
   logic [WIDTH-1:0] next_rise;

   always_comb begin
      next_level = level_o;
      next_rise = '0;
      for (int i = 0; i < WIDTH; i++) begin
         // a change counts only once the last two stages agree
         if (s2[i] == s3[i]) begin
            next_level[i] = s3[i];
            next_rise[i] = s3[i] & ~level_o[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (rst_i) begin
         level_o <= '0;
         rise_o <= '0;
      end else begin
         level_o <= next_level;
         rise_o <= next_rise;
      end
   end
endmodule
`default_nettype wire

// File: verilog/rtc_pkg.sv
package rtc_pkg;

   localparam logic [11:0] ADDR_CTRL_FIRST = 12'hFA0;
   localparam logic [11:0] ADDR_STATUS = 12'hFA4;
   localparam logic [11:0] ADDR_CORR = 12'hFA8;
   localparam logic [11:0] ADDR_AUX = 12'hFAC;
   localparam logic [11:0] ADDR_CAP_A = 12'hFB0;
   localparam logic [11:0] ADDR_CAP_B = 12'hFB4;
   localparam logic [11:0] ADDR_TIME = 12'hFB8;
   localparam logic [11:0] ADDR_DATE = 12'hFBC;
   localparam logic [11:0] ADDR_WEEK = 12'hFC0;

   localparam int CTRL_RUN_BIT = 7;
   localparam int CTRL_MEASURE_BIT = 6;
   localparam int CTRL_SRC_LSB = 1;
   localparam int CTRL_HOLD_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   localparam int AUX_RUN_B_BIT = 0;
   localparam int AUX_MEASURE_B_BIT = 1;
   localparam int AUX_PULSE_EN_BIT = 2;
   localparam int AUX_REF_INT_BIT = 3;
   localparam int AUX_CAP_A_BIT = 4;
   localparam int AUX_CAP_B_BIT = 5;
   localparam int AUX_CLEAR_BIT = 6;

   localparam logic [19:0] CORR_RESET = 20'h07FFF;
   localparam logic [19:0] PRESCALE_INIT = 20'h00000;

   localparam int CLK_PERIOD_NS = 50;
   localparam int STALL_TIME_NS = 100000;
   localparam int STALL_CYCLES = STALL_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      SRC_STOP = 3'b000,
      SRC_LOW = 3'b001,
      SRC_HIGH = 3'b010,
      SRC_HIGH_DIV2 = 3'b011,
      SRC_HIGH_DIV4 = 3'b100,
      SRC_HIGH_DIV8 = 3'b101,
      SRC_HIGH_DIV16 = 3'b110,
      SRC_RESERVED = 3'b111
   } src_sel_t;

   typedef struct packed {
      logic [1:0] leap;
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [2:0] weekday;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } cal_t;

   localparam cal_t CAL_INIT = '{leap: 2'h0, year: 8'h00, month: 8'h01,
      day: 8'h01, weekday: 3'h0, hour: 8'h00, minute: 8'h00,
      second: 8'h00};

   typedef struct packed {
      logic run_b;
      logic measure_b;
      logic pulse_en;
      logic ref_internal;
   } aux_ctrl_t;

   localparam aux_ctrl_t AUX_RESET = '{run_b: 1'b0, measure_b: 1'b0,
      pulse_en: 1'b0, ref_internal: 1'b0};

endpackage
